/* core/arj_format.sv */
// Combinational formatting of a 10-bit code into the register pair
module arj_format
(
    input wire logic right_sel,
    input wire logic [arj_pkg::RES_W-1:0] code,
    output arj_pkg::arj_pair_t pair
);
    //======================================================================
    // Justification mux
    always_comb
    begin
        if (right_sel)
        begin
            // Right format: top bits low in high reg, upper six zero
            pair.high = {6'h00, code[9:8]};
            pair.low = code[7:0];
        end
        else
        begin
            // Left format: code high, low bits at top of low reg
            pair.high = code[9:2];
            pair.low = {code[1:0], 6'h00};
        end
    end
endmodule : arj_format

/* core/arj_result_regs.sv */
// Result registers with APB access and conversion-complete loading
//
// Register access over APB and the address map were chosen for this implementation.
module arj_result_regs
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic NPOR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [arj_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CONV_DONE,
    input wire logic [arj_pkg::RES_W-1:0] CONVERSION_RESULT,
    output logic JUSTIFY_SELECT,
    output logic CONV_START,
    output logic CONV_BUSY
);
    //======================================================================
    // State
    logic [7:0] result_high_reg; // Kept across ordinary resets
    logic [7:0] result_high_next;
    logic [7:0] result_low_reg;
    logic [7:0] result_low_next;
    logic justify_reg; // 1 selects right format
    logic justify_next;
    logic busy_reg; // Conversion in progress
    logic busy_next;
    logic start_reg; // One-cycle start pulse
    logic start_next;
    // Bus answer state
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic err_reg;
    logic err_next;
    // Links to the formatter
    arj_pkg::arj_pair_t fmt_pair;
    arj_pkg::arj_done_t done_evt;
    logic wr_acc; // Write taken this edge
    logic rd_acc; // Read data captured this edge (setup phase)
    logic wr_high; // Software write to the high result word
    logic wr_low; // Software write to the low result word
    logic wr_ctl; // Software write to the control word

    //======================================================================
    // Address decode, used for both read and write
    function automatic logic is_mapped(input logic [arj_pkg::ADDR_W-1:0] a);
        is_mapped = (a == arj_pkg::OFS_RESULT_HIGH) || (a == arj_pkg::OFS_RESULT_LOW)
            || (a == arj_pkg::OFS_CONTROL) || (a == arj_pkg::OFS_STATUS);
    endfunction : is_mapped

    //======================================================================
    // Completion event from the converter
    // The strobe and the code travel together as one carrier
    assign done_evt.done = CONV_DONE;
    // Full 10-bit unsigned code, 1024 steps
    assign done_evt.code = CONVERSION_RESULT;

    //======================================================================
    // Bus strobes
    // A write lands at the access edge; PREADY is always high
    assign wr_acc = PSEL && PENABLE && PWRITE;
    // Read data is sampled at the setup edge and stands through access
    assign rd_acc = PSEL && !PWRITE && !PENABLE;
    // Per-register write strobes
    assign wr_high = wr_acc && (PADDR == arj_pkg::OFS_RESULT_HIGH);
    assign wr_low = wr_acc && (PADDR == arj_pkg::OFS_RESULT_LOW);
    assign wr_ctl = wr_acc && (PADDR == arj_pkg::OFS_CONTROL);

    //======================================================================
    // Formatter instance
    // Justification is taken from the register as it stands at the load edge
    arj_format u_fmt
    (
        .right_sel(justify_reg),
        .code(done_evt.code),
        .pair(fmt_pair)
    );

    //======================================================================
    // Result register next values
    always_comb
    begin
        result_high_next = result_high_reg;
        result_low_next = result_low_reg;
        if (done_evt.done)
        begin
            // Both halves in the same cycle; hardware load wins
            result_high_next = fmt_pair.high;
            result_low_next = fmt_pair.low;
        end
        else if (wr_high)
        begin
            // Software write to the high word; only the low byte is kept
            result_high_next = PWDATA[7:0];
        end
        else if (wr_low)
        begin
            // Software write to the low word; only the low byte is kept
            result_low_next = PWDATA[7:0];
        end
        else
        begin
            // Nothing to do: both words keep their value
            result_high_next = result_high_reg;
            result_low_next = result_low_reg;
        end
    end

    // Result registers: only power reset touches them
    // Ordinary reset is left out of this sensitivity list on purpose
    always_ff @(posedge CLK or negedge NPOR)
    begin
        if (!NPOR)
        begin
            // Power-on or brown-out: contents undefined, zero stands in
            result_high_reg <= 8'h00;
            result_low_reg <= 8'h00;
        end
        else
        begin
            // Load, software write or hold
            result_high_reg <= result_high_next;
            result_low_reg <= result_low_next;
        end
    end

    //======================================================================
    // Control and status next values
    always_comb
    begin
        // Hold by default
        justify_next = justify_reg;
        busy_next = busy_reg;
        // Start is a pulse: low unless a go is taken
        start_next = 1'b0;
        if (wr_ctl)
        begin
            // Format select is plain read/write state
            justify_next = PWDATA[arj_pkg::CTL_JUSTIFY_BIT];
            // A second go while busy is ignored
            if (PWDATA[arj_pkg::CTL_GO_BIT] && !busy_reg)
            begin
                // Caller has waited acquisition time already
                busy_next = 1'b1;
                start_next = 1'b1;
            end
        end
        if (done_evt.done)
        begin
            // Completion ends the conversion and drops the busy flag
            busy_next = 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            // Ordinary reset: left format, idle, no start
            justify_reg <= arj_pkg::CTL_JUSTIFY_RST;
            busy_reg <= arj_pkg::BUSY_RST;
            start_reg <= 1'b0;
        end
        else
        begin
            // Register the computed control values
            justify_reg <= justify_next;
            busy_reg <= busy_next;
            start_reg <= start_next;
        end
    end

    //======================================================================
    // Read data captured in setup phase
    always_comb
    begin
        // Defaults: read data holds, error drops after one access
        rdata_next = rdata_reg;
        err_next = 1'b0;
        if (PSEL && !PENABLE)
        begin
            // Setup phase: flag an unmapped address for the access phase
            err_next = !is_mapped(PADDR);
            // Writes and unmapped reads return zero
            rdata_next = 32'h0000_0000;
        end
        if (rd_acc)
        begin
            // Setup of a read: pick the addressed word
            case (PADDR)
                arj_pkg::OFS_RESULT_HIGH: rdata_next = {24'h000000, result_high_reg};
                arj_pkg::OFS_RESULT_LOW: rdata_next = {24'h000000, result_low_reg};
                arj_pkg::OFS_CONTROL: rdata_next = {31'h00000000, justify_reg};
                arj_pkg::OFS_STATUS: rdata_next = {31'h00000000, busy_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Read data registers
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            // Ordinary reset clears the bus answer
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end
        else
        begin
            // Register the bus answer
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    //======================================================================
    // Outputs
    // Bus answer: zero wait states, error only in the access phase
    assign PRDATA = rdata_reg; // Stands from setup edge to next setup
    assign PREADY = 1'b1; // No wait states
    assign PSLVERR = PSEL && PENABLE && err_reg;
    // Converter side
    assign JUSTIFY_SELECT = justify_reg;
    assign CONV_START = start_reg;
    assign CONV_BUSY = busy_reg;
endmodule : arj_result_regs

/* include/arj_pkg.sv */
// Package with constants and carrier types for the result-register block
//==========================================================================
package arj_pkg;
    //======================================================================
    // Widths
    localparam int RES_W = 10;
    localparam int REG_W = 8;
    localparam int ADDR_W = 12;
    //======================================================================
    // Byte offsets of the registers
    localparam logic [11:0] OFS_RESULT_HIGH = 12'h000;
    localparam logic [11:0] OFS_RESULT_LOW = 12'h004;
    localparam logic [11:0] OFS_CONTROL = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    //======================================================================
    // Field positions
    localparam int CTL_JUSTIFY_BIT = 0;
    localparam int CTL_GO_BIT = 1;
    localparam int STS_BUSY_BIT = 0;
    localparam int HIGH_FIELD_LSB = 0;
    localparam int HIGH_FIELD_W = 2;
    //======================================================================
    // Reset values
    localparam logic CTL_JUSTIFY_RST = 1'b0;
    localparam logic BUSY_RST = 1'b0;
    //======================================================================
    // Result pair carried together
    typedef struct packed {
        logic [REG_W-1:0] high;
        logic [REG_W-1:0] low;
    } arj_pair_t;
    // Completion event towards the result store
    typedef struct packed {
        logic done;
        logic [RES_W-1:0] code;
    } arj_done_t;
endpackage : arj_pkg

/* sim/arj_result_regs_props.sv */
// Checker on the ports of the result-register block
module arj_result_regs_props
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic NPOR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [arj_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire logic CONV_DONE,
    input wire logic [arj_pkg::RES_W-1:0] CONVERSION_RESULT,
    input wire logic JUSTIFY_SELECT,
    input wire logic CONV_START,
    input wire logic CONV_BUSY
);
    //======================================================================
    // Clocking
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!NRST || !NPOR);
    // Read access phase at one address
    sequence s_rd(logic [11:0] a);
        PSEL && PENABLE && !PWRITE && PADDR == a;
    endsequence
    // Right-justified load, then an immediate read
    sequence s_load_rd(logic [11:0] a);
        CONV_DONE && JUSTIFY_SELECT ##2 s_rd(a);
    endsequence
    //======================================================================
    // Properties
    a_high_bits: assert property (s_load_rd(arj_pkg::OFS_RESULT_HIGH) |->
        PRDATA[7:0] == {6'h00, $past(CONVERSION_RESULT[9:8], 2)}) else $error("High bad");
    a_low_bits: assert property (s_load_rd(arj_pkg::OFS_RESULT_LOW) |->
        PRDATA[7:0] == $past(CONVERSION_RESULT[7:0], 2)) else $error("Low bad");
    a_busy_clear: assert property (CONV_DONE |=> !CONV_BUSY) else $error("Busy stuck");
    a_busy_hold: assert property (CONV_BUSY && !CONV_DONE |=> CONV_BUSY) else $error("Busy lost");
    a_go_start: assert property (PSEL && PENABLE && PWRITE && PADDR == arj_pkg::OFS_CONTROL
        && PWDATA[1] && !CONV_BUSY |=> CONV_START && CONV_BUSY ##1 !CONV_START)
        else $error("Start bad");
    a_justify_set: assert property (PSEL && PENABLE && PWRITE && PADDR == arj_pkg::OFS_CONTROL
        |=> JUSTIFY_SELECT == $past(PWDATA[0])) else $error("Justify bad");
    a_bad_addr: assert property (PSEL && PENABLE && PADDR > arj_pkg::OFS_STATUS |->
        PSLVERR && (PWRITE || PRDATA == 32'h0)) else $error("Unmapped bad");
endmodule : arj_result_regs_props

bind arj_result_regs arj_result_regs_props i_arj_result_regs_props (.*);

/* sim/tb_top.sv */
// Self-checking bench for the result-register block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    //======================================================================
    // Signals
    logic CLK = 1'b0, NRST = 1'b0, NPOR = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, er, CONV_DONE = 1'b0, JUSTIFY_SELECT, CONV_START, CONV_BUSY;
    logic [9:0] CONVERSION_RESULT = 10'h000;
    int fails = 0, compares = 0;
    always #2 CLK = ~CLK;
    arj_result_regs i_arj_result_regs (.CLK(CLK), .NRST(NRST), .NPOR(NPOR), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .CONV_DONE(CONV_DONE),
        .CONVERSION_RESULT(CONVERSION_RESULT), .JUSTIFY_SELECT(JUSTIFY_SELECT),
        .CONV_START(CONV_START), .CONV_BUSY(CONV_BUSY));
    //======================================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    // One APB transfer, waits for the answer under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        CONV_DONE <= 1'b0;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 50)
        begin
            fails++;
            complete_run();
        end
    endtask : apb
    // Right-justified conversion, reads in either order straight after completion
    task automatic conv_right(input logic [9:0] c, input logic lf);
        logic [31:0] hi, lo;
        hi = {24'h0, 6'h00, c[9:8]};
        lo = {24'h0, c[7:0]};
        repeat (8) @(posedge CLK);
        apb(1'b1, arj_pkg::OFS_CONTROL, 32'h3);
        #1;
        check({29'h0, CONV_START, CONV_BUSY, JUSTIFY_SELECT}, 32'h7);
        @(posedge CLK);
        CONV_DONE <= 1'b1;
        CONVERSION_RESULT <= c;
        apb(1'b0, lf ? arj_pkg::OFS_RESULT_LOW : arj_pkg::OFS_RESULT_HIGH, 32'h0);
        check(rd, lf ? lo : hi);
        check({31'h0, CONV_BUSY}, 32'h0);
        apb(1'b0, lf ? arj_pkg::OFS_RESULT_HIGH : arj_pkg::OFS_RESULT_LOW, 32'h0);
        check(rd, lf ? hi : lo);
    endtask : conv_right
    // Result registers written and kept across the ordinary reset
    task automatic keep_on_reset;
        apb(1'b1, arj_pkg::OFS_RESULT_HIGH, 32'hA5);
        apb(1'b1, arj_pkg::OFS_RESULT_LOW, 32'h5A);
        @(posedge CLK);
        NRST <= 1'b0;
        repeat (2) @(posedge CLK);
        NRST <= 1'b1;
        apb(1'b0, arj_pkg::OFS_RESULT_HIGH, 32'h0);
        check(rd, 32'hA5);
        apb(1'b0, arj_pkg::OFS_RESULT_LOW, 32'h0);
        check(rd, 32'h5A);
        apb(1'b0, 12'h010, 32'h0);
        check({er, rd[30:0]}, 32'h80000000);
        check({31'h0, PREADY}, 32'h1);
    endtask : keep_on_reset
    // Left-justified conversion, both words read after completion
    task automatic conv_left(input logic [9:0] c);
        repeat (8) @(posedge CLK);
        apb(1'b1, arj_pkg::OFS_CONTROL, 32'h2);
        #1;
        check({29'h0, CONV_START, CONV_BUSY, JUSTIFY_SELECT}, 32'h6);
        @(posedge CLK);
        CONV_DONE <= 1'b1;
        CONVERSION_RESULT <= c;
        apb(1'b0, arj_pkg::OFS_RESULT_HIGH, 32'h0);
        check(rd, {24'h0, c[9:2]});
        apb(1'b0, arj_pkg::OFS_RESULT_LOW, 32'h0);
        check(rd, {24'h0, c[1:0], 6'h00});
    endtask : conv_left
    //======================================================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge CLK);
        NRST <= 1'b1;
        NPOR <= 1'b1;
        keep_on_reset();
        conv_right(10'h000, 1'b0);
        conv_right(10'h3FF, 1'b1);
        conv_right(10'h2A5, 1'b0);
        conv_right(10'h15A, 1'b1);
        conv_left(10'h2A5);
        complete_run();
    end
endmodule : tb_top
